/* hdl/bsd_pkg.sv */
// Purpose: Shared types and constants for the branch and skip decoder
// Assumes: 16-bit word program counter, 8-bit operands, 32-bit Wishbone
// Notes:   Opcode values are an internal code, not the instruction words
package bsd_pkg;

  // Widths
  localparam int PC_W   = 16;  // Program counter width in words
  localparam int OFF_W  = 7;   // Relative branch offset width
  localparam int CNT_W  = 16;  // Event counter width

  // Program counter and event counter steps
  localparam logic [PC_W-1:0] PC_STEP   = 16'h0001; // Plain advance
  localparam logic [PC_W-1:0] SKIP_BASE = 16'h0002; // Skip a one-word op
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001; // Counter increment

  // Status flag positions
  localparam int FLAG_C = 0;   // Unsigned overflow flag
  localparam int FLAG_Z = 1;   // Equality result flag
  localparam int FLAG_N = 2;   // Result sign flag

  // Wishbone register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;  // Control
  localparam logic [7:0] REG_STAT  = 8'h04;  // Status
  localparam logic [7:0] REG_EXEC  = 8'h08;  // Executed count
  localparam logic [7:0] REG_TAKEN = 8'h0C;  // Taken or skipped count

  // Register field positions and reset values
  localparam int CTRL_EN_BIT    = 0;  // Decoder enable
  localparam int CTRL_CLR_BIT   = 1;  // Counter clear, self-clearing
  localparam int STAT_BUSY_BIT  = 0;  // Instruction in flight
  localparam int STAT_TAKEN_BIT = 1;  // Last outcome taken
  localparam int STAT_OP_LSB    = 4;  // Last opcode field
  localparam logic CTRL_EN_RST  = 1'b1;

  // Internal opcode code
  typedef enum logic [3:0] {
    OP_NONE              = 4'h0,
    OP_SKIP_REG_BIT_LOW  = 4'h1,
    OP_SKIP_REG_BIT_HIGH = 4'h2,
    OP_SKIP_IO_BIT_LOW   = 4'h3,
    OP_SKIP_IO_BIT_HIGH  = 4'h4,
    OP_BRANCH_FLAG_BIT_HIGH = 4'h5,
    OP_BRANCH_FLAG_BIT_LOW  = 4'h6,
    OP_BRANCH_EQUAL      = 4'h7,
    OP_BRANCH_UNEQUAL    = 4'h8,
    OP_BRANCH_OVERFLOW_HIGH = 4'h9,
    OP_BRANCH_OVERFLOW_LOW  = 4'hA,
    OP_BRANCH_SAME_OR_ABOVE = 4'hB,
    OP_BRANCH_BELOW      = 4'hC,
    OP_BRANCH_NEGATIVE   = 4'hD,
    OP_BRANCH_POSITIVE   = 4'hE
  } bsd_op_e;

  // Execution states, Gray along idle, hold, last
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HOLD = 2'h1,
    ST_LAST = 2'h3
  } bsd_st_e;

  // Request from the core
  typedef struct packed {
    logic             valid;     // Instruction present
    bsd_op_e          op;        // Decoded operation
    logic [2:0]       bit_sel;   // Bit or flag select
    logic [7:0]       reg_val;   // General register read port
    logic [7:0]       io_val;    // I/O register read port
    logic [7:0]       flags;     // status_flags_register value
    logic [OFF_W-1:0] offset;    // Signed relative offset
    logic [PC_W-1:0]  pc;        // Address of this instruction
    logic             next_two;  // Following instruction is two words
  } bsd_req_s;

  // Answer to the core
  typedef struct packed {
    logic            done;       // Last cycle of the instruction
    logic            taken;      // Branch taken or skip done
    logic [PC_W-1:0] pc_next;    // New program counter
    logic [7:0]      flags;      // Flags handed back untouched
  } bsd_rsp_s;

endpackage : bsd_pkg

/* hdl/bsd_decode.sv */
// Purpose: Conditional skip and relative branch decode and execute
// Assumes: Core holds req stable only for the cycle it is accepted
// Notes:   Wishbone classic slave for control, status and counters
//
// Contract
// - Register bit clear skips next, PC plus 2/3
// - Register bit set skips next, PC plus 2/3
// - I/O bit clear skips next, PC plus 2/3
// - I/O bit set skips next, PC plus 2/3
// - Flag bit set branches to PC plus k+1
// - Flag bit clear branches to PC plus k+1
// - Equal branches when zero flag set
// - Unequal branches when zero flag clear
// - Overflow high branches when carry set
// - Overflow low branches when carry clear
// - Same-or-above and below alias carry branches
// - Negative branches when sign flag set
// - Positive branches when sign flag clear
// - Status flags are never modified
// - Skips take 1, 2 or 3 cycles
// - Branches take 1 or 2 cycles
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module bsd_decode
  import bsd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire bsd_req_s    req,
  output var  bsd_rsp_s    rsp,
  output var  logic        busy,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o
);

  // Whole module state
  typedef struct packed {
    bsd_st_e          st;        // Execution state
    bsd_rsp_s         rsp;       // Registered answer
    logic             busy;      // Instruction in flight
    logic             en;        // Control enable
    logic             taken;     // Held outcome
    logic [PC_W-1:0]  pc_next;   // Held target
    logic [7:0]       flags;     // Held flags
    bsd_op_e          last_op;   // Last accepted opcode
    logic [CNT_W-1:0] exec_cnt;  // Accepted instructions
    logic [CNT_W-1:0] take_cnt;  // Taken branches and skips
    logic             ack;       // Wishbone acknowledge
    logic [31:0]      rdat;      // Wishbone read data
  } bsd_state_s;

  bsd_state_s       cur;         // Registered state
  bsd_state_s       next_cur;    // Next state
  logic             acc;         // Request accepted this cycle
  logic             bit_reg;     // Selected general register bit
  logic             bit_io;      // Selected I/O register bit
  logic             bit_flag;    // Selected status flag bit
  logic             is_skip;     // Operation is a skip
  logic             cond;        // Skip or branch condition met
  logic [PC_W-1:0]  off_ext;     // Sign-extended offset
  logic [PC_W-1:0]  tgt_rel;     // Relative branch target
  logic [PC_W-1:0]  tgt_skip;    // Skip target
  logic [PC_W-1:0]  tgt_fall;    // Fall-through target
  logic             wb_req;      // New Wishbone access
  logic             ctrl_wr;     // Write to control byte 0

  // Bit selection and targets
  always_comb
  begin
    bit_reg  = req.reg_val[req.bit_sel];
    bit_io   = req.io_val[req.bit_sel];
    bit_flag = req.flags[req.bit_sel];
    off_ext  = {{(PC_W-OFF_W){req.offset[OFF_W-1]}}, req.offset};
    tgt_rel  = req.pc + off_ext + PC_STEP;
    tgt_skip = req.pc + SKIP_BASE + PC_W'(req.next_two);
    tgt_fall = req.pc + PC_STEP;
  end

  // Condition decode per operation
  always_comb
  begin
    is_skip = 1'b0;
    cond    = 1'b0;
    case (req.op)
      OP_SKIP_REG_BIT_LOW:
      begin
        is_skip = 1'b1;
        cond    = !bit_reg;
      end
      OP_SKIP_REG_BIT_HIGH:
      begin
        is_skip = 1'b1;
        cond    = bit_reg;
      end
      OP_SKIP_IO_BIT_LOW:
      begin
        is_skip = 1'b1;
        cond    = !bit_io;
      end
      OP_SKIP_IO_BIT_HIGH:
      begin
        is_skip = 1'b1;
        cond    = bit_io;
      end
      OP_BRANCH_FLAG_BIT_HIGH: cond = bit_flag;
      OP_BRANCH_FLAG_BIT_LOW:  cond = !bit_flag;
      OP_BRANCH_EQUAL:         cond = req.flags[FLAG_Z];
      OP_BRANCH_UNEQUAL:       cond = !req.flags[FLAG_Z];
      OP_BRANCH_OVERFLOW_HIGH,
      OP_BRANCH_BELOW:         cond = req.flags[FLAG_C];
      OP_BRANCH_OVERFLOW_LOW,
      OP_BRANCH_SAME_OR_ABOVE: cond = !req.flags[FLAG_C];
      OP_BRANCH_NEGATIVE:      cond = req.flags[FLAG_N];
      OP_BRANCH_POSITIVE:      cond = !req.flags[FLAG_N];
      default:                 cond = 1'b0;
    endcase
  end

  // Acceptance and bus decode
  always_comb
  begin
    acc     = (cur.st == ST_IDLE) && cur.en && req.valid &&
              (req.op != OP_NONE);
    wb_req  = wb_cyc_i && wb_stb_i && !cur.ack;
    ctrl_wr = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL);
  end

  // Next state
  always_comb
  begin
    next_cur          = cur;
    next_cur.rsp.done = 1'b0;
    next_cur.ack      = 1'b0;
    // Counter clear first, so a same-cycle count still lands
    if (ctrl_wr && wb_dat_i[CTRL_CLR_BIT])
    begin
      next_cur.exec_cnt = '0;
      next_cur.take_cnt = '0;
    end
    if (ctrl_wr)
    begin
      next_cur.en = wb_dat_i[CTRL_EN_BIT];
    end
    case (cur.st)
      // Take a new instruction
      ST_IDLE:
      begin
        if (acc)
        begin
          next_cur.last_op  = req.op;
          next_cur.taken    = cond;
          next_cur.flags    = req.flags;
          next_cur.exec_cnt = next_cur.exec_cnt + CNT_ONE;
          if (cond)
          begin
            next_cur.take_cnt = next_cur.take_cnt + CNT_ONE;
          end
          if (!cond)
          begin
            // Not taken: one cycle, fall through
            next_cur.rsp.done    = 1'b1;
            next_cur.rsp.taken   = 1'b0;
            next_cur.rsp.pc_next = tgt_fall;
            next_cur.rsp.flags   = req.flags;
          end
          else if (is_skip)
          begin
            // Skip: two cycles, three past a two-word op
            next_cur.pc_next = tgt_skip;
            next_cur.st      = req.next_two ? ST_HOLD : ST_LAST;
            next_cur.busy    = 1'b1;
          end
          else
          begin
            // Taken branch: two cycles
            next_cur.pc_next = tgt_rel;
            next_cur.st      = ST_LAST;
            next_cur.busy    = 1'b1;
          end
        end
      end
      // Extra cycle for a two-word skip
      ST_HOLD:
      begin
        next_cur.st = ST_LAST;
      end
      // Final cycle, hand back the answer
      ST_LAST:
      begin
        next_cur.st          = ST_IDLE;
        next_cur.busy        = 1'b0;
        next_cur.rsp.done    = 1'b1;
        next_cur.rsp.taken   = cur.taken;
        next_cur.rsp.pc_next = cur.pc_next;
        next_cur.rsp.flags   = cur.flags;
      end
      default:
      begin
        next_cur.st   = ST_IDLE;
        next_cur.busy = 1'b0;
      end
    endcase
    // Wishbone answer, one cycle after the strobe
    if (wb_req)
    begin
      next_cur.ack  = 1'b1;
      next_cur.rdat = '0;
      case (wb_adr_i)
        REG_CTRL:  next_cur.rdat[CTRL_EN_BIT] = cur.en;
        REG_STAT:
        begin
          next_cur.rdat[STAT_BUSY_BIT]  = cur.busy;
          next_cur.rdat[STAT_TAKEN_BIT] = cur.taken;
          next_cur.rdat[STAT_OP_LSB +: 4] = cur.last_op;
        end
        REG_EXEC:  next_cur.rdat[CNT_W-1:0] = cur.exec_cnt;
        REG_TAKEN: next_cur.rdat[CNT_W-1:0] = cur.take_cnt;
        default:   next_cur.rdat = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cur    <= '0;
      cur.st <= ST_IDLE;
      cur.en <= CTRL_EN_RST;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state
  always_comb
  begin
    rsp      = cur.rsp;
    busy     = cur.busy;
    wb_dat_o = cur.rdat;
    wb_ack_o = cur.ack;
  end

  // Fall through one cycle later
  sequence s_fall;
    ##1 (rsp.done && !rsp.taken && rsp.pc_next == $past(tgt_fall));
  endsequence

  // Taken branch: busy one cycle, then done at the target
  sequence s_jump;
    ##1 (busy && !rsp.done)
    ##1 (rsp.done && rsp.taken && rsp.pc_next == $past(tgt_rel, 2));
  endsequence

  // One-word skip done two cycles later
  sequence s_skip2;
    ##2 (rsp.done && rsp.taken && rsp.pc_next == $past(tgt_skip, 2));
  endsequence

  // Two-word skip done three cycles later
  sequence s_skip3;
    !rsp.done [*3]
    ##1 (rsp.done && rsp.taken && rsp.pc_next == $past(tgt_skip, 3));
  endsequence

  property p_skip_reg_low;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_SKIP_REG_BIT_LOW && !bit_reg && !req.next_two
      |-> s_skip2;
  endproperty
  a_skip_reg_low: assert property (p_skip_reg_low)
    else $error("register bit clear skip wrong");

  property p_skip_reg_high;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_SKIP_REG_BIT_HIGH && bit_reg && req.next_two
      |-> s_skip3;
  endproperty
  a_skip_reg_high: assert property (p_skip_reg_high)
    else $error("register bit set skip wrong");

  property p_skip_io_low;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_SKIP_IO_BIT_LOW && !bit_io && req.next_two
      |-> s_skip3;
  endproperty
  a_skip_io_low: assert property (p_skip_io_low)
    else $error("io bit clear skip wrong");

  property p_skip_io_high;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_SKIP_IO_BIT_HIGH && bit_io && !req.next_two
      |-> s_skip2;
  endproperty
  a_skip_io_high: assert property (p_skip_io_high)
    else $error("io bit set skip wrong");

  property p_flag_high;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_BRANCH_FLAG_BIT_HIGH && bit_flag |-> s_jump;
  endproperty
  a_flag_high: assert property (p_flag_high)
    else $error("flag set branch wrong");

  property p_flag_low;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_BRANCH_FLAG_BIT_LOW && bit_flag |-> s_fall;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("flag clear branch taken on set flag");

  property p_equal;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_BRANCH_EQUAL
      |-> if (req.flags[FLAG_Z]) s_jump else s_fall;
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal branch wrong");

  property p_unequal;
    @(posedge clk_sys) disable iff (!nrst)
    acc && req.op == OP_BRANCH_UNEQUAL
      |-> if (req.flags[FLAG_Z]) s_fall else s_jump;
  endproperty
  a_unequal: assert property (p_unequal)
    else $error("unequal branch wrong");

  property p_below;
    @(posedge clk_sys) disable iff (!nrst)
    acc && (req.op == OP_BRANCH_BELOW || req.op == OP_BRANCH_OVERFLOW_HIGH)
      |-> if (req.flags[FLAG_C]) s_jump else s_fall;
  endproperty
  a_below: assert property (p_below)
    else $error("carry set branch wrong");

  property p_same_above;
    @(posedge clk_sys) disable iff (!nrst)
    acc && (req.op == OP_BRANCH_SAME_OR_ABOVE ||
            req.op == OP_BRANCH_OVERFLOW_LOW)
      |-> if (req.flags[FLAG_C]) s_fall else s_jump;
  endproperty
  a_same_above: assert property (p_same_above)
    else $error("carry clear branch wrong");

  property p_sign;
    @(posedge clk_sys) disable iff (!nrst)
    acc && (req.op == OP_BRANCH_NEGATIVE || req.op == OP_BRANCH_POSITIVE)
      |-> if (req.flags[FLAG_N] == (req.op == OP_BRANCH_NEGATIVE))
            s_jump else s_fall;
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign branch wrong");

  property p_flags_kept;
    @(posedge clk_sys) disable iff (!nrst)
    acc && !cond |-> ##1 (rsp.flags == $past(req.flags));
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags changed");

  property p_skip_none;
    @(posedge clk_sys) disable iff (!nrst)
    acc && is_skip && !cond |-> s_fall;
  endproperty
  a_skip_none: assert property (p_skip_none)
    else $error("unskipped skip not one cycle");

  property p_back_offset;
    @(posedge clk_sys) disable iff (!nrst)
    acc && !is_skip && cond && req.offset[OFF_W-1] && req.pc[PC_W-1]
      |-> ##2 (rsp.pc_next <= $past(req.pc, 2));
  endproperty
  a_back_offset: assert property (p_back_offset)
    else $error("negative offset did not go backward");

endmodule : bsd_decode

`default_nettype wire

/* sim/bsd_decode_bench.sv */
// Purpose: Self-checking bench for the branch and skip decoder
// Assumes: Row table drives plain cases, awkward cases follow by hand
// Notes:   Bus and instruction port driven on the rising edge only
`timescale 1ns/10ps
`default_nettype none

module bsd_decode_bench
  import bsd_pkg::*;
  ;

  // One table row: inputs and the expected outcome
  typedef struct packed {
    bsd_op_e    op;   // Operation under test
    logic [2:0] sel;  // Bit or flag select
    logic [7:0] val;  // Value of the tested source
    logic [6:0] off;  // Signed branch offset
    logic       two;  // Following instruction is two words
    logic       tk;   // Taken or skipped expected
  } bsd_row_s;

  logic        clk_sys;    // Core clock
  logic        nrst;       // Synchronous reset, active low
  bsd_req_s    req;        // Instruction request
  bsd_rsp_s    rsp;        // Instruction answer
  logic        busy;       // Extra cycles in flight
  logic        wb_cyc_i;   // Bus cycle
  logic        wb_stb_i;   // Bus strobe
  logic        wb_we_i;    // Bus write
  logic [7:0]  wb_adr_i;   // Bus address
  logic [3:0]  wb_sel_i;   // Bus lanes
  logic [31:0] wb_dat_i;   // Bus write data
  logic [31:0] wb_dat_o;   // Bus read data
  logic        wb_ack_o;   // Bus acknowledge
  int          bad_count;  // Mismatches
  int          num_checks; // Comparisons
  logic [31:0] rd;         // Last bus read
  int          cnt;        // Done pulses seen

  // Both outcomes of every operation; untested sources get the inverse
  bsd_row_s rows [28] = '{
    '{OP_SKIP_REG_BIT_LOW,     3'h3, 8'hF7, 7'h00, 1'b0, 1'b1},
    '{OP_SKIP_REG_BIT_LOW,     3'h3, 8'h08, 7'h00, 1'b0, 1'b0},
    '{OP_SKIP_REG_BIT_HIGH,    3'h7, 8'h80, 7'h00, 1'b1, 1'b1},
    '{OP_SKIP_REG_BIT_HIGH,    3'h0, 8'hFE, 7'h00, 1'b0, 1'b0},
    '{OP_SKIP_IO_BIT_LOW,      3'h5, 8'hDF, 7'h00, 1'b1, 1'b1},
    '{OP_SKIP_IO_BIT_LOW,      3'h5, 8'h20, 7'h00, 1'b1, 1'b0},
    '{OP_SKIP_IO_BIT_HIGH,     3'h1, 8'h02, 7'h00, 1'b0, 1'b1},
    '{OP_SKIP_IO_BIT_HIGH,     3'h1, 8'hFD, 7'h00, 1'b0, 1'b0},
    '{OP_BRANCH_FLAG_BIT_HIGH, 3'h6, 8'h40, 7'h10, 1'b0, 1'b1},
    '{OP_BRANCH_FLAG_BIT_HIGH, 3'h6, 8'hBF, 7'h10, 1'b0, 1'b0},
    '{OP_BRANCH_FLAG_BIT_LOW,  3'h4, 8'hEF, 7'h7E, 1'b0, 1'b1},
    '{OP_BRANCH_FLAG_BIT_LOW,  3'h4, 8'h10, 7'h7E, 1'b0, 1'b0},
    '{OP_BRANCH_EQUAL,         3'h7, 8'h02, 7'h3F, 1'b0, 1'b1},
    '{OP_BRANCH_EQUAL,         3'h7, 8'hFD, 7'h3F, 1'b0, 1'b0},
    '{OP_BRANCH_UNEQUAL,       3'h7, 8'hFD, 7'h40, 1'b0, 1'b1},
    '{OP_BRANCH_UNEQUAL,       3'h7, 8'h02, 7'h40, 1'b0, 1'b0},
    '{OP_BRANCH_OVERFLOW_HIGH, 3'h7, 8'h01, 7'h01, 1'b0, 1'b1},
    '{OP_BRANCH_OVERFLOW_HIGH, 3'h7, 8'hFE, 7'h01, 1'b0, 1'b0},
    '{OP_BRANCH_OVERFLOW_LOW,  3'h7, 8'hFE, 7'h05, 1'b0, 1'b1},
    '{OP_BRANCH_OVERFLOW_LOW,  3'h7, 8'h01, 7'h05, 1'b0, 1'b0},
    '{OP_BRANCH_SAME_OR_ABOVE, 3'h7, 8'hFE, 7'h05, 1'b0, 1'b1},
    '{OP_BRANCH_SAME_OR_ABOVE, 3'h7, 8'h01, 7'h05, 1'b0, 1'b0},
    '{OP_BRANCH_BELOW,         3'h7, 8'h01, 7'h7F, 1'b0, 1'b1},
    '{OP_BRANCH_BELOW,         3'h7, 8'hFE, 7'h7F, 1'b0, 1'b0},
    '{OP_BRANCH_NEGATIVE,      3'h7, 8'h04, 7'h02, 1'b0, 1'b1},
    '{OP_BRANCH_NEGATIVE,      3'h7, 8'hFB, 7'h02, 1'b0, 1'b0},
    '{OP_BRANCH_POSITIVE,      3'h7, 8'hFB, 7'h70, 1'b0, 1'b1},
    '{OP_BRANCH_POSITIVE,      3'h7, 8'h04, 7'h70, 1'b0, 1'b0}
  };

  // Device under test
  bsd_decode bsd_decode_inst (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .req      (req),
    .rsp      (rsp),
    .busy     (busy),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o)
  );

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Value compare
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Cycle count compare
  task automatic check_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_cnt

  // Build a request; the sources not under test carry the inverse
  function automatic bsd_req_s make_req(bsd_row_s r, logic [15:0] pc);
    bsd_req_s q;
    q.valid    = 1'b1;
    q.op       = r.op;
    q.bit_sel  = r.sel;
    q.reg_val  = (r.op inside {OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH})
                 ? r.val : ~r.val;
    q.io_val   = (r.op inside {OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH})
                 ? r.val : ~r.val;
    q.flags    = (r.op > OP_SKIP_IO_BIT_HIGH) ? r.val : ~r.val;
    q.offset   = r.off;
    q.pc       = pc;
    q.next_two = r.two;
    return q;
  endfunction : make_req

  // Classic single bus cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20)
      bad_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_xfer

  // One instruction, presented for a single cycle, answer checked
  task automatic run_op(input bsd_row_s r, input logic [15:0] pc);
    bsd_req_s    q;
    logic        skip;
    logic [15:0] exp_pc;
    int          n;
    skip = (r.op <= OP_SKIP_IO_BIT_HIGH);
    q = make_req(r, pc);
    req <= q;
    @(posedge clk_sys);
    req.valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rsp.done !== 1'b1 && n < 20);
    exp_pc = !r.tk ? pc + PC_STEP
           : skip ? pc + SKIP_BASE + 16'(r.two)
           : pc + {{9{r.off[6]}}, r.off} + PC_STEP;
    check_val(32'(rsp.taken), 32'(r.tk));
    check_val(32'(rsp.pc_next), 32'(exp_pc));
    check_val(32'(rsp.flags), 32'(q.flags));
    check_cnt(n, !r.tk ? 1 : skip ? 2 + int'(r.two) : 2);
  endtask : run_op

  // Count done pulses over a number of edges
  task automatic count_done(input int edges);
    cnt = 0;
    repeat (edges)
    begin
      @(posedge clk_sys);
      if (rsp.done === 1'b1)
        cnt++;
    end
  endtask : count_done

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    clk_sys  = 1'b0;
    nrst     = 1'b0;
    req      = '0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    bad_count  = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // Quiet outputs out of reset
    check_val(32'(rsp), 32'h00000000);
    check_val(32'({busy, wb_ack_o}), 32'h00000000);
    // Enable resets high; clear both counters
    wb_xfer(1'b0, REG_CTRL, 32'h00000000);
    check_val(rd, 32'h00000001);
    wb_xfer(1'b1, REG_CTRL, 32'h00000003);
    // Table of plain cases
    for (int i = 0; i < 28; i++)
    begin
      run_op(rows[i], 16'h1000 + 16'(i) * 16'h0040);
    end
    // Counters, status, unmapped and read-only places
    wb_xfer(1'b0, REG_EXEC, 32'h00000000);
    check_val(rd, 32'h0000001C);
    wb_xfer(1'b0, REG_TAKEN, 32'h00000000);
    check_val(rd, 32'h0000000E);
    wb_xfer(1'b1, REG_STAT, 32'h000000FF);
    wb_xfer(1'b0, REG_STAT, 32'h00000000);
    check_val(rd, 32'h000000E0);
    wb_xfer(1'b0, 8'h10, 32'h00000000);
    check_val(rd, 32'h00000000);
    // Three not-taken ops back to back, one per cycle; count as they go
    cnt = 0;
    for (int i = 0; i < 3; i++)
    begin
      req <= make_req(rows[1], 16'h0200 + 16'(i));
      @(posedge clk_sys);
      if (rsp.done === 1'b1)
        cnt++;
    end
    req.valid <= 1'b0;
    @(posedge clk_sys);
    if (rsp.done === 1'b1)
      cnt++;
    check_cnt(cnt, 3);
    check_val(32'(rsp.pc_next), 32'h00000203);
    count_done(4);
    check_cnt(cnt, 0);
    // Taken branch across the top of memory, second request while busy
    req <= make_req('{OP_BRANCH_EQUAL, 3'h7, 8'h02, 7'h01, 1'b0, 1'b1},
                    16'hFFFF);
    @(posedge clk_sys);
    req <= make_req(rows[1], 16'h0300);
    @(posedge clk_sys);
    check_val(32'(busy), 32'h00000001);
    req.valid <= 1'b0;
    count_done(4);
    check_cnt(cnt, 1);
    check_val(32'(rsp.pc_next), 32'h00000001);
    // Disabled decoder ignores a request
    wb_xfer(1'b1, REG_CTRL, 32'h00000000);
    req <= make_req(rows[0], 16'h0400);
    @(posedge clk_sys);
    req.valid <= 1'b0;
    count_done(4);
    check_cnt(cnt, 0);
    wb_xfer(1'b1, REG_CTRL, 32'h00000001);
    run_op(rows[2], 16'h0500);
    // Backward branch from the upper half of memory
    run_op(rows[10], 16'h8000);
    // Mid-run reset brings enable back high and counters to zero
    wb_xfer(1'b1, REG_CTRL, 32'h00000000);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    check_val(32'({busy, wb_ack_o}), 32'h00000000);
    wb_xfer(1'b0, REG_CTRL, 32'h00000000);
    check_val(rd, 32'h00000001);
    wb_xfer(1'b0, REG_EXEC, 32'h00000000);
    check_val(rd, 32'h00000000);
    complete_run();
  end

endmodule : bsd_decode_bench

`default_nettype wire
